//--- sdh_defines.svh
// Constants of the start/done/interrupt handshake block
`ifndef SDH_DEFINES_SVH
`define SDH_DEFINES_SVH

// Word indices of the registers; byte address is four times the index
`define SDH_IDX_KICK_STATUS 6'h00
`define SDH_IDX_IRQ_ENABLE  6'h01
`define SDH_IDX_IRQ_CLEAR   6'h02

// Status bit positions
`define SDH_ST_IRQ_EN_BIT   0
`define SDH_ST_ACTIVE_BIT   1
`define SDH_ST_IRQ_BIT      2

// Enable register field
`define SDH_EN_BIT          0

// Reset values
`define SDH_IRQ_EN_RST      1'b0
`define SDH_WORD_ZERO       32'h0000_0000

// Slave window base, compared on the bits above the 256-byte window
`define SDH_BASE_ADDR       32'h4000_0000
`define SDH_WIN_LSB         8
`define SDH_IDX_LSB         2

`endif

//--- sdh_pkg.sv
// Types of the start/done/interrupt handshake block
`default_nettype none

package sdh_pkg;

  // Bus clock domain state
  typedef struct packed {
    logic        irq_en;    // Completion interrupt enable
    logic        irq_pend;  // Sticky completion flag
    logic        active;    // Unit busy as seen by software
    logic        kick_tgl;  // Kick event toward unit domain
    logic        done_seen; // Last done toggle consumed
    logic        ack;       // Transfer acknowledge pulse
    logic        ack_hold;  // Transfer already answered
    logic [31:0] rdata;     // Read data register
  } sdh_bus_type;

  // Unit clock domain state
  typedef struct packed {
    logic kick;       // Kick request to fabric logic
    logic kick_seen;  // Last kick toggle consumed
    logic done_tgl;   // Done event toward bus domain
  } sdh_unit_type;

endpackage : sdh_pkg

`default_nettype wire

//--- sdh_sync.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
`default_nettype none

module sdh_sync #(
  parameter logic RST_VAL = 1'b0  // Value held during reset
) (
  // Clock and reset of the destination domain
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Level from the other domain
  input  wire logic d_i,
  // Synchronised level
  output logic      q_o
);

  logic [1:0] stage_ff;  // Stage 0 feeds only stage 1
  logic [1:0] nxt_stage;

  // Shift toward the output
  always_comb begin
    nxt_stage = {stage_ff[0], d_i};
    if (!rst_n_i) begin
      nxt_stage = {RST_VAL, RST_VAL};
    end
  end

  // Register both stages
  always_ff @(posedge clk_i) begin
    stage_ff <= nxt_stage;
  end

  assign q_o = stage_ff[1];

endmodule : sdh_sync

`default_nettype wire

//--- sdh_top.sv
// Processor-to-unit start/done handshake with completion interrupt
// What this block does
// - Status bit 0 reads interrupt enable
// - Status bit 1 high from kick to done
// - Status bit 2 mirrors interrupt output
// - Offset 0x01 write loads enable bit 0
// - Enable clears to zero on reset
// - Any write to 0x02 clears pending interrupt unless a completion lands the same cycle
// - Enabled completion raises interrupt output
// - Bus write drives the kick request
// - Shared counts must cross domains safely
// - Offset 0x00 write kicks until done
// - Bus side on bus clock, unit side fabric clock
`timescale 1ns/100ps
`default_nettype none

`include "sdh_defines.svh"

module sdh_top #(
  parameter logic [31:0] BASE_ADDR = `SDH_BASE_ADDR  // Slave window base
) (
  // Bus clock and synchronous reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Peripheral bus slave, inbound
  input  wire logic        OPB_select,
  input  wire logic        OPB_RNW,
  input  wire logic [31:0] OPB_ABus,
  input  wire logic [31:0] OPB_DBus,
  // Peripheral bus slave, outbound
  output logic             Sln_xferAck,
  output logic [31:0]      Sln_DBus,
  output logic             Sln_errAck,
  output logic             Sln_retry,
  output logic             Sln_toutSup,
  // Completion interrupt toward processor
  output logic             completion_irq_o,
  // Fabric side, own clock
  input  wire logic        unit_clk_i,
  input  wire logic        unit_done_i,
  output logic             unit_kick_o
);

  // Bus domain state
  sdh_pkg::sdh_bus_type  bus_ff;
  sdh_pkg::sdh_bus_type  nxt_bus;
  // Unit domain state
  sdh_pkg::sdh_unit_type unit_ff;
  sdh_pkg::sdh_unit_type nxt_unit;

  // Crossing outputs
  logic unit_rst_n;     // Reset seen in unit domain
  logic kick_tgl_sync;  // Kick toggle in unit domain
  logic done_tgl_sync;  // Done toggle in bus domain

  // Decode helpers
  logic       hit;        // Access falls in our window
  logic [5:0] idx;        // Register word index
  logic       take;       // Access taken this cycle
  logic       wr;         // Write taken
  logic       done_evt;   // One completion event
  logic       irq_level;  // Gated interrupt level
  logic       kick_wr;    // Kick write to word 0
  logic       en_wr;      // Enable write to word 1
  logic       clr_wr;     // Clear write to word 2
  logic       rd_status;  // Status read of word 0
  logic       rd_enable;  // Enable read-back of word 1

  // Status word built from live state
  function automatic logic [31:0] status_word(
    input logic en, input logic act, input logic irq);
    logic [31:0] w;
    w = `SDH_WORD_ZERO;
    w[`SDH_ST_IRQ_EN_BIT] = en;
    w[`SDH_ST_ACTIVE_BIT] = act;
    w[`SDH_ST_IRQ_BIT]    = irq;
    return w;
  endfunction : status_word

  // Reset carried into the unit clock domain
  sdh_sync #(
    .RST_VAL (1'b0)
  ) u_rst_sync (
    .clk_i   (unit_clk_i),
    .rst_n_i (1'b1),
    .d_i     (rst_n_i),
    .q_o     (unit_rst_n)
  );

  // Kick event into the unit domain; only one-bit toggles cross here,
  // so a shared count added later needs a handshake of its own
  sdh_sync #(
    .RST_VAL (1'b0)
  ) u_kick_sync (
    .clk_i   (unit_clk_i),
    .rst_n_i (unit_rst_n),
    .d_i     (bus_ff.kick_tgl),
    .q_o     (kick_tgl_sync)
  );

  // Done event into the bus domain
  sdh_sync #(
    .RST_VAL (1'b0)
  ) u_done_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (unit_ff.done_tgl),
    .q_o     (done_tgl_sync)
  );

  // Window decode; only the upper bits are compared to keep it small
  assign hit  = OPB_select &&
                (OPB_ABus[31:`SDH_WIN_LSB] == BASE_ADDR[31:`SDH_WIN_LSB]);
  assign idx  = OPB_ABus[`SDH_IDX_LSB +: 6];
  // One answer per select; the hold keeps a long select from re-acking
  assign take = hit && !bus_ff.ack && !bus_ff.ack_hold;
  assign wr   = take && !OPB_RNW;

  // Per-register strobes; unmapped words decode to nothing
  assign kick_wr   = wr && (idx == `SDH_IDX_KICK_STATUS);
  assign en_wr     = wr && (idx == `SDH_IDX_IRQ_ENABLE);
  assign clr_wr    = wr && (idx == `SDH_IDX_IRQ_CLEAR);
  assign rd_status = take && OPB_RNW && (idx == `SDH_IDX_KICK_STATUS);
  assign rd_enable = take && OPB_RNW && (idx == `SDH_IDX_IRQ_ENABLE);

  // Each toggle change is one completion, seen once
  assign done_evt  = done_tgl_sync != bus_ff.done_seen;
  assign irq_level = bus_ff.irq_pend && bus_ff.irq_en;

  // Bus domain next state
  always_comb begin
    nxt_bus           = bus_ff;
    nxt_bus.ack       = take;
    nxt_bus.done_seen = done_tgl_sync;
    // Answer held until select drops
    if (!OPB_select) begin
      nxt_bus.ack_hold = 1'b0;
    end else if (take) begin
      nxt_bus.ack_hold = 1'b1;
    end
    // Read data only during the ack cycle, zero otherwise; the
    // idle-zero bus lets slaves be OR-ed together without a mux
    nxt_bus.rdata = `SDH_WORD_ZERO;
    if (rd_status) begin
      // Live status, sampled at the taking edge
      nxt_bus.rdata = status_word(bus_ff.irq_en, bus_ff.active,
                                  irq_level);
    end else if (rd_enable) begin
      // Enable read-back in its own field
      nxt_bus.rdata[`SDH_EN_BIT] = bus_ff.irq_en;
    end
    // Completion ends activity
    if (done_evt) begin
      nxt_bus.active = 1'b0;
    end
    // Kick write; a second kick while busy is absorbed
    if (kick_wr && !nxt_bus.active) begin
      nxt_bus.active   = 1'b1;
      nxt_bus.kick_tgl = ~bus_ff.kick_tgl;
    end
    // Enable write
    if (en_wr) begin
      nxt_bus.irq_en = OPB_DBus[`SDH_EN_BIT];
    end
    // Clear write; a completion in the same cycle wins
    if (clr_wr) begin
      nxt_bus.irq_pend = 1'b0;
    end
    if (done_evt) begin
      nxt_bus.irq_pend = 1'b1;
    end
    // Synchronous reset
    if (!rst_n_i) begin
      nxt_bus          = '0;
      nxt_bus.irq_en   = `SDH_IRQ_EN_RST;
    end
  end

  // Bus domain register
  always_ff @(posedge ref_clk_i) begin
    bus_ff <= nxt_bus;
  end

  // Unit domain next state
  always_comb begin
    nxt_unit           = unit_ff;
    nxt_unit.kick_seen = kick_tgl_sync;
    // New kick has priority over a lingering done level
    if (kick_tgl_sync != unit_ff.kick_seen) begin
      nxt_unit.kick = 1'b1;
    end else if (unit_ff.kick && unit_done_i) begin
      nxt_unit.kick     = 1'b0;
      nxt_unit.done_tgl = ~unit_ff.done_tgl;
    end
    // Done is only looked at while a kick stands; a done level still
    // high when the next kick lands ends that job one edge later
    // Synchronous reset from the synchronised level
    if (!unit_rst_n) begin
      nxt_unit = '0;
    end
  end

  // Unit domain register
  always_ff @(posedge unit_clk_i) begin
    unit_ff <= nxt_unit;
  end

  // Outputs
  assign Sln_xferAck      = bus_ff.ack;
  assign Sln_DBus         = bus_ff.rdata;
  assign Sln_errAck       = 1'b0;
  assign Sln_retry        = 1'b0;
  assign Sln_toutSup      = 1'b0;
  assign completion_irq_o = irq_level;
  assign unit_kick_o      = unit_ff.kick;

endmodule : sdh_top

`default_nettype wire

//--- sdh_unit_model.sv
// Behavioural model of the fabric processing unit
`timescale 1ns/100ps
`default_nettype none
module sdh_unit_model (
  // Fabric clock and kick from the block
  input  wire logic       unit_clk_i,
  input  wire logic       kick_i,
  // Work length in fabric cycles, zero answers promptly
  input  wire logic [7:0] work_len_i,
  // Finished flag back to the block
  output logic            done_o
);
  logic [7:0] left_ff = 8'h00;  // Work cycles still to run
  initial done_o = 1'b0;
  // Count down while kicked; done holds until the kick is withdrawn
  always @(posedge unit_clk_i) begin
    if (!kick_i) begin
      done_o  <= 1'b0;
      left_ff <= work_len_i;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end else begin
      done_o <= 1'b1;
    end
  end
endmodule : sdh_unit_model
`default_nettype wire

//--- sdh_top_assertions.sv
// Port-level property checker of the handshake block
`timescale 1ns/100ps
`default_nettype none
module sdh_checker #(
  parameter logic [31:0] BASE_ADDR = 32'h4000_0000  // Window base
) (
  // Bus side
  input wire logic        ref_clk_i, rst_n_i, OPB_select, OPB_RNW,
  input wire logic [31:0] OPB_ABus, OPB_DBus, Sln_DBus,
  input wire logic        Sln_xferAck, Sln_errAck, Sln_retry,
  input wire logic        Sln_toutSup, completion_irq_o,
  // Fabric side
  input wire logic        unit_clk_i, unit_done_i, unit_kick_o
);
  // Mapped request, then its answer one edge later
  sequence s_req(rnw, idx);
    OPB_select && OPB_RNW == rnw && OPB_ABus[7:2] == idx
      && OPB_ABus[31:8] == BASE_ADDR[31:8];
  endsequence
  sequence s_done(rnw, idx);
    s_req(rnw, idx) ##1 Sln_xferAck;
  endsequence
  a_ack_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    Sln_xferAck |=> !Sln_xferAck) else $error("ack longer than a cycle");
  a_ack_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(Sln_xferAck) |-> $past(OPB_select)) else $error("ack unasked");
  a_idle_data: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !Sln_xferAck |-> Sln_DBus == 32'h0000_0000) else $error("data idle");
  a_unused_tied: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(Sln_errAck || Sln_retry || Sln_toutSup)) else $error("tied outputs");
  a_status_irq: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_done(1, 0) |-> Sln_DBus[2] == $past(completion_irq_o)
      && (!Sln_DBus[2] || Sln_DBus[0])) else $error("status irq");
  a_disable_irq: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_req(0, 1) ##0 !OPB_DBus[0]) ##1 Sln_xferAck |-> !completion_irq_o)
    else $error("irq while disabled");
  a_clear_irq: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_done(0, 2) |-> !completion_irq_o) else $error("irq kept");
  a_kick_hold: assert property (
    @(posedge unit_clk_i) disable iff (!rst_n_i)
    unit_kick_o && !unit_done_i |=> unit_kick_o) else $error("kick dropped");
  a_kick_end: assert property (
    @(posedge unit_clk_i) disable iff (!rst_n_i)
    unit_kick_o && unit_done_i |=> !unit_kick_o) else $error("kick kept");
endmodule : sdh_checker
bind sdh_top sdh_checker #(.BASE_ADDR(BASE_ADDR)) u_chk (.ref_clk_i, .rst_n_i,
  .OPB_select, .OPB_RNW, .OPB_ABus, .OPB_DBus, .Sln_DBus, .Sln_xferAck,
  .Sln_errAck, .Sln_retry, .Sln_toutSup, .completion_irq_o, .unit_clk_i,
  .unit_done_i, .unit_kick_o);
`default_nettype wire

//--- test_sdh_top.sv
// Self-checking bench of the start/done handshake block
`timescale 1ns/100ps
`default_nettype none
`include "sdh_defines.svh"
module test_sdh_top;
  logic        ref_clk_i = 1'b0, unit_clk_i = 1'b0, rst_n_i = 1'b0;
  logic        OPB_select = 1'b0, OPB_RNW = 1'b0;  // Bus request
  logic [31:0] OPB_ABus = 32'h0000_0000, OPB_DBus = 32'h0000_0000;
  logic [7:0]  work_len = 8'h00;  // Model work length
  logic        ack, irq, done, kick, err, rty, tsup;
  logic [31:0] rdat, rd, d;
  int          num_errors = 0, num_checks = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  always #3.5 unit_clk_i = ~unit_clk_i;  // Unrelated fabric clock
  sdh_top uut (.ref_clk_i, .rst_n_i, .OPB_select, .OPB_RNW, .OPB_ABus,
    .OPB_DBus, .Sln_xferAck(ack), .Sln_DBus(rdat), .Sln_errAck(err),
    .Sln_retry(rty), .Sln_toutSup(tsup), .completion_irq_o(irq),
    .unit_clk_i, .unit_done_i(done), .unit_kick_o(kick));
  sdh_unit_model u_unit (.unit_clk_i, .kick_i(kick), .work_len_i(work_len),
    .done_o(done));
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Expected status word
  function automatic logic [31:0] status(input logic en, act, pend);
    return {29'h0, pend & en, act, en};
  endfunction : status
  // One transfer, held until acknowledged, bounded wait
  task automatic xfer(input logic rnw, input logic [5:0] idx,
                      input logic [31:0] wd);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    {OPB_select, OPB_RNW, OPB_DBus} = {1'b1, rnw, wd};
    OPB_ABus = `SDH_BASE_ADDR | {24'h00_0000, idx, 2'b00};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = rdat;
    if (n >= 16) chk("ack", 32'h0000_0001, 32'h0000_0000);
    @(negedge ref_clk_i);
    {OPB_select, OPB_DBus} = {1'b0, ~wd};
  endtask : xfer
  // Kick, wait for completion, service the interrupt
  task automatic job(input logic en);
    int n;
    n = 0;
    xfer(1'b0, `SDH_IDX_IRQ_ENABLE, ($urandom & 32'hFFFF_FFFE) | en);
    work_len = 8'($urandom_range(0, 40));  // Stands for load and unload
    xfer(1'b0, `SDH_IDX_KICK_STATUS, $urandom);
    xfer(1'b1, `SDH_IDX_KICK_STATUS, 32'h0000_0000);
    chk("busy", status(en, 1'b1, 1'b0), rd);
    xfer(1'b0, `SDH_IDX_KICK_STATUS, $urandom);
    do begin
      xfer(1'b1, `SDH_IDX_KICK_STATUS, 32'h0000_0000);
      n++;
    end while (rd[1] !== 1'b0 && n < 200);
    chk("done", status(en, 1'b0, 1'b1), rd);
    chk("irq", {31'h0, en}, {31'h0, irq});
    if (!en) begin
      xfer(1'b0, `SDH_IDX_IRQ_ENABLE, 32'h0000_0001);
      chk("late irq", 32'h0000_0001, {31'h0, irq});
    end
    xfer(1'b0, `SDH_IDX_IRQ_CLEAR, $urandom);
    xfer(1'b1, `SDH_IDX_KICK_STATUS, 32'h0000_0000);
    chk("clear", status(1'b1, 1'b0, 1'b0), rd);
  endtask : job
  // Print counts and verdict, then stop
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    void'($urandom(32'h8f5eeb18));
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    xfer(1'b1, `SDH_IDX_KICK_STATUS, 32'h0000_0000);
    chk("reset", 32'h0000_0000, rd);
    chk("tied", 32'h0000_0000, {29'h0, err, rty, tsup});
    repeat (4) begin
      d = $urandom;
      xfer(1'b0, `SDH_IDX_IRQ_ENABLE, d);
      xfer(1'b1, `SDH_IDX_KICK_STATUS, 32'h0000_0000);
      chk("enable", status(d[0], 1'b0, 1'b0), rd);
      xfer(1'b1, `SDH_IDX_IRQ_ENABLE, 32'h0000_0000);
      chk("enable rb", {31'h0, d[0]}, rd);
    end
    xfer(1'b0, 6'($urandom_range(3, 63)), $urandom);
    xfer(1'b1, `SDH_IDX_KICK_STATUS, 32'h0000_0000);
    chk("unmapped wr", status(d[0], 1'b0, 1'b0), rd);
    xfer(1'b1, 6'($urandom_range(3, 63)), 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    job(1'b1);
    job(1'b0);
    repeat (3) job(1'($urandom));
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;  // Second reset with enable set
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    xfer(1'b1, `SDH_IDX_KICK_STATUS, 32'h0000_0000);
    chk("rereset", 32'h0000_0000, rd);
    end_of_test();
  end
  // Watchdog against a hung handshake
  initial begin
    #40000;
    num_errors++;
    end_of_test();
  end
endmodule : test_sdh_top
`default_nettype wire
